// ---- bench/atcs_osc_model.sv ----
`timescale 1ns/1ps
// Timer crystal or external clock source, 125 ns period
module atcs_osc_model #(
  parameter realtime HALF_NS = 62.5
) (
  input  wire logic xtal_en,
  input  wire logic ext_en,
  output logic      osc
);
  // Runs only while the device enables crystal or buffer, idles low otherwise
  initial begin
    osc = 1'b0;
    #3.1;
    forever begin
      #HALF_NS;
      if (xtal_en || ext_en) osc = ~osc;
      else osc = 1'b0;
    end
  end
endmodule : atcs_osc_model

// ---- bench/atcs_top_chk.sv ----
`timescale 1ns/1ps
// Port-level checks of the asynchronous timer block
module atcs_top_chk
  import atcs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timer_osc_in,
  input wire logic        compare_out,
  input wire logic        xtal_osc_enable,
  input wire logic        ext_clock_buf_enable,
  input wire logic        cpu_halted,
  input wire logic        irq
);
  import atcs_pkg::*;
  logic [3:0] halt_cnt_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles the core has been held, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) halt_cnt_reg <= 4'h0;
    else if (!cpu_halted) halt_cnt_reg <= 4'h0;
    else if (halt_cnt_reg != 4'hF) halt_cnt_reg <= halt_cnt_reg + 4'h1;
  end
  // Address phase then data phase of one write or read
  sequence s_wr(logic [7:0] a);
    hsel && hready && htrans[1] && hwrite && haddr == a ##1 1'b1;
  endsequence
  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == a ##1 1'b1;
  endsequence
  a_bus_okay: assert property (!hresp && hreadyout) else $error("bus response not OKAY or not ready");
  a_res_zero: assert property (s_rd(ATCS_STATUS_OFF) |-> !hrdata[7]) else $error("reserved bit read one");
  a_ext_buf: assert property (s_wr(ATCS_STATUS_OFF) ##0 (hwdata[5] && hwdata[6])
    |-> ##[1:3] (ext_clock_buf_enable && !xtal_osc_enable)) else $error("external buffer not enabled");
  a_xtal_run: assert property (s_wr(ATCS_STATUS_OFF) ##0 (hwdata[5] && !hwdata[6])
    |-> ##[1:3] (xtal_osc_enable && !ext_clock_buf_enable)) else $error("crystal not enabled");
  a_sel_io: assert property (s_wr(ATCS_STATUS_OFF) ##0 !hwdata[5]
    |-> ##[1:3] (!xtal_osc_enable && !ext_clock_buf_enable)) else $error("oscillator on in io mode");
  a_cmp_slow: assert property ((xtal_osc_enable || ext_clock_buf_enable) && $changed(compare_out)
    |=> $stable(compare_out)[*8]) else $error("compare pin moved faster than timer clock");
  a_mask_off: assert property (s_wr(ATCS_IRQ_MSK_OFF) ##0 (hwdata[3:0] == 4'h0)
    |-> ##[1:3] !irq) else $error("irq high with all masked");
  a_sleep_go: assert property (s_wr(ATCS_SLEEP_OFF) ##0 hwdata[0] |-> ##[0:2] cpu_halted)
    else $error("sleep request not taken");
  a_halt_len: assert property ($fell(cpu_halted) |-> halt_cnt_reg >= 4'h4)
    else $error("core released too early");
  // Wake flag shows on irq, then the core stays held two more cycles
  sequence s_halt_tail;
    cpu_halted [*3] ##1 !cpu_halted;
  endsequence
  a_halt_four: assert property (cpu_halted && $rose(irq) |-> s_halt_tail)
    else $error("halt after wake not four cycles");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data changed without read");
endmodule : atcs_top_chk
bind atcs_top atcs_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .timer_osc_in(timer_osc_in), .compare_out(compare_out), .xtal_osc_enable(xtal_osc_enable),
  .ext_clock_buf_enable(ext_clock_buf_enable), .cpu_halted(cpu_halted), .irq(irq));

// ---- bench/atcs_top_test.sv ----
`timescale 1ns/1ps
module atcs_top_test;
  import atcs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, timer_osc_in, hreadyout, hresp;
  logic        compare_out, xtal_osc_enable, ext_clock_buf_enable, cpu_halted, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  atcs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_osc_in(timer_osc_in), .compare_out(compare_out), .xtal_osc_enable(xtal_osc_enable),
    .ext_clock_buf_enable(ext_clock_buf_enable), .cpu_halted(cpu_halted), .irq(irq));
  atcs_osc_model u_osc (.xtal_en(xtal_osc_enable), .ext_en(ext_clock_buf_enable), .osc(timer_osc_in));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Verdict and end of run
  task stop_test();
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // One single AHB-Lite transfer, read data left in rd
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ATCS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask : chk

  // Poll a register until the masked bits are clear
  task poll(input logic [7:0] a, input logic [7:0] m);
    for (int i = 0; i < 400; i++) begin
      xfer(a, 1'b0, 8'h00);
      if ((rd[7:0] & m) === 8'h00) break;
    end
    chk("busy_clear", 32'h0000_0000, {24'h00_0000, rd[7:0] & m});
  endtask : poll

  initial begin
    int i;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(ATCS_STATUS_OFF, 1'b0, 8'h00);
    chk("status_rst", 32'h0000_0000, rd);
    xfer(ATCS_STATUS_OFF, 1'b1, 8'hC0);
    xfer(ATCS_STATUS_OFF, 1'b0, 8'h00);
    chk("status_res", 32'h0000_0040, rd);
    xfer(ATCS_STATUS_OFF, 1'b1, 8'h60);
    repeat (3) @(posedge hclk);
    chk("buf_xtal", 32'h0000_0002, 32'({ext_clock_buf_enable, xtal_osc_enable}));
    // Counter load through holding register, then safe read
    xfer(ATCS_COUNT_OFF, 1'b1, 8'h55);
    poll(ATCS_STATUS_OFF, 8'h10);
    xfer(ATCS_CTLB_OFF, 1'b1, 8'h00);
    poll(ATCS_STATUS_OFF, 8'h01);
    xfer(ATCS_COUNT_OFF, 1'b0, 8'h00);
    chk("count", 32'h0000_0055, rd);
    // Compare match event, interrupt, mask and clear
    xfer(ATCS_CMPA_OFF, 1'b1, 8'h58);
    xfer(ATCS_IRQ_MSK_OFF, 1'b1, 8'h02);
    xfer(ATCS_CTLB_OFF, 1'b1, 8'h01);
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge hclk);
    chk("irq", 32'h0000_0001, 32'(irq));
    chk("cmp_pin", 32'h0000_0001, 32'(compare_out));
    xfer(ATCS_IRQ_STS_OFF, 1'b0, 8'h00);
    chk("sts_cmpa", 32'h0000_0002, rd & 32'h0000_0002);
    xfer(ATCS_IRQ_MSK_OFF, 1'b1, 8'h00);
    repeat (3) @(posedge hclk);
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    xfer(ATCS_IRQ_STS_OFF, 1'b1, 8'h02);
    xfer(ATCS_IRQ_STS_OFF, 1'b0, 8'h00);
    chk("sts_clear", 32'h0000_0000, rd & 32'h0000_0002);
    // Sleep until a timer event wakes the core
    xfer(ATCS_IRQ_MSK_OFF, 1'b1, 8'h08);
    xfer(ATCS_SLEEP_OFF, 1'b1, 8'h01);
    repeat (2) @(posedge hclk);
    chk("halted", 32'h0000_0001, 32'(cpu_halted));
    for (i = 0; i < 5000 && cpu_halted !== 1'b0; i++) @(posedge hclk);
    chk("woke", 32'h0000_0000, 32'(cpu_halted));
    xfer(ATCS_IRQ_STS_OFF, 1'b0, 8'h00);
    chk("wake_flag", 32'h0000_0008, rd & 32'h0000_0008);
    // Clock source change and crystal mode
    xfer(ATCS_STATUS_OFF, 1'b1, 8'h40);
    xfer(ATCS_CMPA_OFF, 1'b0, 8'h00);
    chk("cmp_lost", 32'h0000_0000, rd);
    chk("osc_off", 32'h0000_0000, 32'({ext_clock_buf_enable, xtal_osc_enable}));
    xfer(ATCS_STATUS_OFF, 1'b1, 8'h20);
    repeat (3) @(posedge hclk);
    chk("xtal_on", 32'h0000_0001, 32'({ext_clock_buf_enable, xtal_osc_enable}));
    // Unmapped address reads zero
    xfer(8'h24, 1'b1, 8'hFF);
    xfer(8'h24, 1'b0, 8'h00);
    chk("unmapped", 32'h0000_0000, rd);
    stop_test();
  end
endmodule : atcs_top_test

// ---- logic/atcs_pkg.sv ----
package atcs_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] ATCS_STATUS_OFF  = 8'h00;
  localparam logic [7:0] ATCS_COUNT_OFF   = 8'h04;
  localparam logic [7:0] ATCS_CMPA_OFF    = 8'h08;
  localparam logic [7:0] ATCS_CMPB_OFF    = 8'h0C;
  localparam logic [7:0] ATCS_CTLA_OFF    = 8'h10;
  localparam logic [7:0] ATCS_CTLB_OFF    = 8'h14;
  localparam logic [7:0] ATCS_IRQ_STS_OFF = 8'h18;
  localparam logic [7:0] ATCS_IRQ_MSK_OFF = 8'h1C;
  localparam logic [7:0] ATCS_SLEEP_OFF   = 8'h20;

  // Status register field positions
  localparam int ATCS_RES_BIT  = 7;
  localparam int ATCS_EXT_BIT  = 6;
  localparam int ATCS_ASEL_BIT = 5;
  localparam int ATCS_CUB_BIT  = 4;
  localparam int ATCS_CMAB_BIT = 3;
  localparam int ATCS_CMBB_BIT = 2;
  localparam int ATCS_CRAB_BIT = 1;
  localparam int ATCS_CRBB_BIT = 0;

  // Interrupt status bit positions
  localparam int ATCS_EV_OVF  = 0;
  localparam int ATCS_EV_CMPA = 1;
  localparam int ATCS_EV_CMPB = 2;
  localparam int ATCS_EV_WAKE = 3;

  // Reset values
  localparam logic [7:0]  ATCS_BYTE_RST = 8'h00;
  localparam logic [3:0]  ATCS_EV_RST   = 4'h0;

  // Timing counts
  localparam int          ATCS_HALT_CYCLES = 4;
  localparam logic [2:0]  ATCS_HALT_CNT    = 3'(ATCS_HALT_CYCLES);
  localparam int          ATCS_FLAG_SYNC   = 3;

  // AHB-Lite encodings
  localparam logic [1:0]  ATCS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  ATCS_HTRANS_SEQ    = 2'h3;

  // Control fields that the timer domain consumes
  typedef struct packed {
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic       run;
  } atcs_cfg_t;

  // Sleep / wake controller states
  typedef enum logic [1:0] {
    ATCS_AWAKE  = 2'b00,
    ATCS_ASLEEP = 2'b01,
    ATCS_WAKING = 2'b10,
    ATCS_HALTED = 2'b11
  } atcs_pwr_t;

endpackage : atcs_pkg

// ---- logic/atcs_sync2.sv ----
`timescale 1ns/1ps
// Two-flop level synchroniser into the hclk domain
module atcs_sync2 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : atcs_sync2

// ---- logic/atcs_timer_core.sv ----
`timescale 1ns/1ps
// 8-bit counter stepped once per timer tick, with compare output
module atcs_timer_core
  import atcs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tick,
  input  wire atcs_cfg_t  cfg,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic [7:0]      count,
  output logic            ovf_ev,
  output logic            cmpa_ev,
  output logic            cmpb_ev,
  output logic            cmp_out
);

  // Counter advances and is loaded only on timer-clock ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= ATCS_BYTE_RST;
    end else if (tick && load) begin
      count <= load_val;
    end else if (tick && cfg.run) begin
      count <= count + 8'h01;
    end
  end

  // Events and compare pin all change on the tick edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_ev  <= 1'b0;
      cmpa_ev <= 1'b0;
      cmpb_ev <= 1'b0;
      cmp_out <= 1'b0;
    end else begin
      ovf_ev  <= tick && cfg.run && !load && (count == 8'hFF);
      cmpa_ev <= tick && cfg.run && (count == cfg.cmp_a);
      cmpb_ev <= tick && cfg.run && (count == cfg.cmp_b);
      if (tick && cfg.run && (count == cfg.cmp_a)) begin
        cmp_out <= ~cmp_out;
      end
    end
  end

endmodule : atcs_timer_core

// ---- logic/atcs_top.sv ----
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - In sleep, an interrupt starts wake-up on the next timer-clock tick.
// - After wake, processor stays halted four cycles before servicing.
// - Counter reads return an I/O-clock copy refreshed each timer rising edge.
// - After power-save wake, reads show pre-sleep value until next timer edge; here the copy also refreshes on every tick during sleep.
// - Interrupt flags reach processor side three cycles plus one timer cycle.
// - Compare output pin changes on the timer clock, not processor clock; here compare_out is registered on hclk after the matching tick.
// - Status bit 7 is reserved and reads zero.
// - Bit 6 with async enables external clock buffer; crystal runs only when zero.
// - Bit 5 selects timer clock: zero I/O clock, one oscillator input.
// - Changing clock select may corrupt counter, compares and control registers.
// - Bit 4 sets on async counter write, clears once counter loaded.
// - Update-busy zero means counter can accept a new value.
module atcs_top
  import atcs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timer_osc_in,
  output logic             compare_out,
  output logic             xtal_osc_enable,
  output logic             ext_clock_buf_enable,
  output logic             cpu_halted,
  output logic             irq
);

  // Bus address phase capture
  logic       wr_pend_reg;
  logic [7:0] addr_reg;
  // Software-visible registers
  logic       ext_clock_in_enable_reg;
  logic       async_clock_select_reg;
  logic [7:0] count_tmp_reg;
  logic       counter_update_pending_reg;
  logic [7:0] cmp_a_reg;
  logic [7:0] cmp_b_reg;
  logic [7:0] ctl_a_reg;
  logic [7:0] ctl_b_reg;
  logic [3:0] busy_other_reg;
  logic [3:0] irq_sts_reg;
  logic [3:0] irq_msk_reg;
  logic [7:0] count_copy_reg;
  logic       sleep_req_reg;
  // Timer clock edge detection
  logic       osc_sync;
  logic       osc_prev_reg;
  logic       osc_rise;
  logic       tick;
  // Sleep controller
  atcs_pwr_t  pwr_reg;
  atcs_pwr_t  pwr_next;
  logic [2:0] halt_cnt_reg;
  // Timer core connections
  atcs_cfg_t  cfg;
  logic [7:0] count;
  logic       ovf_ev;
  logic       cmpa_ev;
  logic       cmpb_ev;
  logic       cmp_pin;
  logic [3:0] ev_raw;
  logic [3:0] ev_dly_reg [ATCS_FLAG_SYNC];
  logic [3:0] ev_sync;
  logic       wr_now;
  logic       rd_now;
  logic [31:0] rd_mux;

  // Returns the address match for one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Timer pin synchronised before any edge detection
  atcs_sync2 u_osc_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .async_in(timer_osc_in),
    .sync_out(osc_sync)
  );

  // Rising-edge detector on the synchronised oscillator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync;
    end
  end

  assign osc_rise = osc_sync && !osc_prev_reg;
  // Clock source: I/O clock ticks every cycle, else oscillator edges
  assign tick = async_clock_select_reg ? osc_rise : 1'b1;

  assign cfg.cmp_a = cmp_a_reg;
  assign cfg.cmp_b = cmp_b_reg;
  assign cfg.run   = (ctl_b_reg[2:0] != 3'h0);

  atcs_timer_core u_core (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .cfg     (cfg),
    .load    (counter_update_pending_reg),
    .load_val(count_tmp_reg),
    .count   (count),
    .ovf_ev  (ovf_ev),
    .cmpa_ev (cmpa_ev),
    .cmpb_ev (cmpb_ev),
    .cmp_out (cmp_pin)
  );

  // Bus phase decode
  assign wr_now = hsel && hready && htrans[1] && hwrite;
  assign rd_now = hsel && hready && htrans[1] && !hwrite;

  // Address phase register, data phase follows one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= ATCS_BYTE_RST;
    end else begin
      wr_pend_reg <= wr_now;
      if (wr_now || rd_now) begin
        addr_reg <= haddr;
      end
    end
  end

  // Clock control bits; a source change clears the compare and control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_clock_in_enable_reg <= 1'b0;
      async_clock_select_reg  <= 1'b0;
    end else if (wr_pend_reg && hit(addr_reg, ATCS_STATUS_OFF)) begin
      ext_clock_in_enable_reg <= hwdata[ATCS_EXT_BIT];
      async_clock_select_reg  <= hwdata[ATCS_ASEL_BIT];
    end
  end

  // Counter write holding register and busy flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_tmp_reg              <= ATCS_BYTE_RST;
      counter_update_pending_reg <= 1'b0;
    end else if (wr_pend_reg && hit(addr_reg, ATCS_COUNT_OFF)) begin
      count_tmp_reg              <= hwdata[7:0];
      counter_update_pending_reg <= 1'b1;
    end else if (tick) begin
      counter_update_pending_reg <= 1'b0;
    end
  end

  // Compare and control registers; corrupted (cleared) on source change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_a_reg      <= ATCS_BYTE_RST;
      cmp_b_reg      <= ATCS_BYTE_RST;
      ctl_a_reg      <= ATCS_BYTE_RST;
      ctl_b_reg      <= ATCS_BYTE_RST;
      busy_other_reg <= 4'h0;
    end else if (wr_pend_reg && hit(addr_reg, ATCS_STATUS_OFF)
                 && (hwdata[ATCS_ASEL_BIT] != async_clock_select_reg)) begin
      cmp_a_reg      <= ATCS_BYTE_RST;
      cmp_b_reg      <= ATCS_BYTE_RST;
      ctl_a_reg      <= ATCS_BYTE_RST;
      ctl_b_reg      <= ATCS_BYTE_RST;
      busy_other_reg <= 4'h0;
    end else begin
      if (tick) begin
        busy_other_reg <= 4'h0;
      end
      if (wr_pend_reg && hit(addr_reg, ATCS_CMPA_OFF)) begin
        cmp_a_reg         <= hwdata[7:0];
        busy_other_reg[3] <= async_clock_select_reg;
      end
      if (wr_pend_reg && hit(addr_reg, ATCS_CMPB_OFF)) begin
        cmp_b_reg         <= hwdata[7:0];
        busy_other_reg[2] <= async_clock_select_reg;
      end
      if (wr_pend_reg && hit(addr_reg, ATCS_CTLA_OFF)) begin
        ctl_a_reg         <= hwdata[7:0];
        busy_other_reg[1] <= async_clock_select_reg;
      end
      if (wr_pend_reg && hit(addr_reg, ATCS_CTLB_OFF)) begin
        ctl_b_reg         <= hwdata[7:0];
        busy_other_reg[0] <= async_clock_select_reg;
      end
    end
  end

  // Read copy of the counter, refreshed only on timer edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_copy_reg <= ATCS_BYTE_RST;
    end else if (tick) begin
      count_copy_reg <= count;
    end
  end

  // Overflow and compare flags delayed three processor cycles after the core pulse, four after the tick; wake flag added undelayed
  assign ev_raw = {1'b0, cmpb_ev, cmpa_ev, ovf_ev};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ATCS_FLAG_SYNC; i++) begin
        ev_dly_reg[i] <= ATCS_EV_RST;
      end
    end else begin
      ev_dly_reg[0] <= ev_raw;
      for (int i = 1; i < ATCS_FLAG_SYNC; i++) begin
        ev_dly_reg[i] <= ev_dly_reg[i-1];
      end
    end
  end
  assign ev_sync = ev_dly_reg[ATCS_FLAG_SYNC-1] | {(pwr_reg == ATCS_WAKING) && tick, 3'b000};

  // Sticky status, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sts_reg <= ATCS_EV_RST;
      irq_msk_reg <= ATCS_EV_RST;
    end else begin
      if (wr_pend_reg && hit(addr_reg, ATCS_IRQ_STS_OFF)) begin
        irq_sts_reg <= (irq_sts_reg & ~hwdata[3:0]) | ev_sync;
      end else begin
        irq_sts_reg <= irq_sts_reg | ev_sync;
      end
      if (wr_pend_reg && hit(addr_reg, ATCS_IRQ_MSK_OFF)) begin
        irq_msk_reg <= hwdata[3:0];
      end
    end
  end

  // Sleep request register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_req_reg <= 1'b0;
    end else if (wr_pend_reg && hit(addr_reg, ATCS_SLEEP_OFF)) begin
      sleep_req_reg <= hwdata[0];
    end else if (pwr_reg == ATCS_ASLEEP) begin
      sleep_req_reg <= 1'b0;
    end
  end

  // Sleep/wake sequencing
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      ATCS_AWAKE: begin
        if (sleep_req_reg) begin
          pwr_next = ATCS_ASLEEP;
        end
      end
      ATCS_ASLEEP: begin
        if (|ev_raw[2:0]) begin
          pwr_next = ATCS_WAKING;
        end
      end
      ATCS_WAKING: begin
        if (tick) begin
          pwr_next = ATCS_HALTED;
        end
      end
      ATCS_HALTED: begin
        if (halt_cnt_reg == 3'h1) begin
          pwr_next = ATCS_AWAKE;
        end
      end
    endcase
  end

  // Power state and halt counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_reg      <= ATCS_AWAKE;
      halt_cnt_reg <= 3'h0;
    end else begin
      pwr_reg <= pwr_next;
      if (pwr_reg == ATCS_WAKING) begin
        halt_cnt_reg <= ATCS_HALT_CNT;
      end else if (halt_cnt_reg != 3'h0) begin
        halt_cnt_reg <= halt_cnt_reg - 3'h1;
      end
    end
  end

  // Read data mux, decoded in the address phase so data stands in the data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr)
      ATCS_STATUS_OFF: begin
        rd_mux[ATCS_RES_BIT]  = 1'b0;
        rd_mux[ATCS_EXT_BIT]  = ext_clock_in_enable_reg;
        rd_mux[ATCS_ASEL_BIT] = async_clock_select_reg;
        rd_mux[ATCS_CUB_BIT]  = counter_update_pending_reg;
        rd_mux[3:0]           = busy_other_reg;
      end
      ATCS_COUNT_OFF:   rd_mux[7:0] = count_copy_reg;
      ATCS_CMPA_OFF:    rd_mux[7:0] = cmp_a_reg;
      ATCS_CMPB_OFF:    rd_mux[7:0] = cmp_b_reg;
      ATCS_CTLA_OFF:    rd_mux[7:0] = ctl_a_reg;
      ATCS_CTLB_OFF:    rd_mux[7:0] = ctl_b_reg;
      ATCS_IRQ_STS_OFF: rd_mux[3:0] = irq_sts_reg;
      ATCS_IRQ_MSK_OFF: rd_mux[3:0] = irq_msk_reg;
      ATCS_SLEEP_OFF:   rd_mux[0]   = sleep_req_reg;
      default:          rd_mux      = 32'h0000_0000;
    endcase
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata               <= 32'h0000_0000;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
      compare_out          <= 1'b0;
      xtal_osc_enable      <= 1'b0;
      ext_clock_buf_enable <= 1'b0;
      cpu_halted           <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
      if (rd_now) begin
        hrdata <= rd_mux;
      end
      compare_out          <= cmp_pin;
      ext_clock_buf_enable <= ext_clock_in_enable_reg && async_clock_select_reg;
      xtal_osc_enable      <= async_clock_select_reg && !ext_clock_in_enable_reg;
      cpu_halted           <= (pwr_next != ATCS_AWAKE);
      irq                  <= |(irq_sts_reg & irq_msk_reg);
    end
  end

endmodule : atcs_top
